// file: clock_output_sync_config_pkg.sv
// Constants shared by the clock output and sync configuration block
package clock_output_sync_config_pkg;

	// ------------------------------------------------------------
	// Serial word and register addresses
	// ------------------------------------------------------------
	localparam int          WORD_W            = 32;
	localparam int          ADDR_W            = 5;
	localparam logic [4:0]  ADDR_FMT_A        = 5'h06;
	localparam logic [4:0]  ADDR_FMT_B        = 5'h07;
	localparam logic [4:0]  ADDR_FMT_C        = 5'h08;
	localparam logic [4:0]  ADDR_FIXED        = 5'h09;
	localparam logic [4:0]  ADDR_OSC          = 5'h0A;
	localparam logic [4:0]  ADDR_SYNC_XTAL    = 5'h0B;
	localparam logic [4:0]  ADDR_TEST_LOCK    = 5'h0C;
	localparam logic [31:0] REG_RESET         = 32'h0000_0000;

	// ------------------------------------------------------------
	// Clock output format fields
	// ------------------------------------------------------------
	localparam int          NUM_OUT           = 12;
	localparam int          NUM_GROUP         = 6;
	localparam int          FMT_PER_WORD      = 4;
	localparam int          FMT_W             = 4;
	localparam int          FMT_LSB           = 16;
	localparam logic [3:0]  FMT_POWERDOWN     = 4'h0;
	localparam logic [3:0]  FMT_LAST_VALID    = 4'hE;

	// ------------------------------------------------------------
	// Oscillator buffer control word fields
	// ------------------------------------------------------------
	localparam int          OSC1_AMP_LSB      = 28;
	localparam int          OSC1_AMP_W        = 2;
	localparam int          OSC0_FMT_LSB      = 24;
	localparam int          OSC1_EN_BIT       = 23;
	localparam int          OSC0_EN_BIT       = 22;
	localparam int          OSC1_MUX_BIT      = 21;
	localparam int          OSC0_MUX_BIT      = 20;
	localparam int          OSC_DIV_LSB       = 16;
	localparam int          OSC_DIV_W         = 3;
	localparam logic [2:0]  DIV_CODE_EIGHT    = 3'h0;
	localparam logic [2:0]  DIV_CODE_TWO_ALT  = 3'h1;
	localparam logic [3:0]  DIV_RATIO_EIGHT   = 4'h8;
	localparam logic [3:0]  DIV_RATIO_TWO     = 4'h2;

	// ------------------------------------------------------------
	// Sync and crystal control word fields
	// ------------------------------------------------------------
	localparam int          NOSYNC_LSB        = 20;
	localparam int          SYNC_POL_BIT      = 16;
	localparam int          SYNC_TYPE_LSB     = 12;
	localparam int          SYNC_TYPE_W       = 2;
	localparam int          XTAL_BIT          = 5;
	localparam logic [1:0]  SYNC_TYPE_PLAIN   = 2'h0;
	localparam logic [1:0]  SYNC_TYPE_PULLUP  = 2'h1;
	localparam logic [1:0]  SYNC_TYPE_PULLDN  = 2'h2;

	// ------------------------------------------------------------
	// Test and lock pin control word fields
	// ------------------------------------------------------------
	localparam int          TEST_SRC_LSB      = 27;
	localparam int          TEST_SRC_W        = 5;
	localparam int          TEST_TYPE_LSB     = 24;
	localparam int          TEST_TYPE_W       = 3;
	localparam int          HOLD_LOCK_BIT     = 23;
	localparam logic [4:0]  SRC_LOW           = 5'h00;
	localparam logic [4:0]  SRC_LOCK          = 5'h02;
	localparam logic [4:0]  SRC_FB            = 5'h0D;
	localparam logic [4:0]  SRC_FB_HALF       = 5'h0E;
	localparam logic [4:0]  SRC_REF           = 5'h11;
	localparam logic [4:0]  SRC_REF_HALF      = 5'h12;
	localparam logic [2:0]  TYPE_PUSH         = 3'h3;
	localparam logic [2:0]  TYPE_PUSH_INV     = 3'h4;
	localparam logic [2:0]  TYPE_OPEN_SOURCE  = 3'h5;
	localparam logic [2:0]  TYPE_OPEN_DRAIN   = 3'h6;

	// ------------------------------------------------------------
	// Lock qualifier and automatic sync timing
	// ------------------------------------------------------------
	localparam int          LOCK_CNT_W        = 14;
	localparam int          SYS_PERIOD_PS     = 5000;
	localparam int          AUTO_SYNC_NS      = 40;
	localparam int          AUTO_SYNC_CYCLES  =
		(AUTO_SYNC_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int          AUTO_CNT_W        = 4;

	// ------------------------------------------------------------
	// Reserved code flag positions
	// ------------------------------------------------------------
	localparam int          ERR_OSC0_FMT      = 12;
	localparam int          ERR_SYNC_TYPE     = 13;
	localparam int          ERR_TEST_SRC      = 14;
	localparam int          ERR_TEST_TYPE     = 15;
	localparam int          ERR_W             = 16;

	// Sync sequencer states
	typedef enum logic {SYNC_IDLE, SYNC_ACTIVE} sync_state_t;

endpackage

// file: pin_sync3.sv
// Three-stage pin synchroniser with second/third stage agreement
module pin_sync3 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_arst_n,
	// Raw pins and filtered levels
	input  wire logic [WIDTH-1:0] i_pin,
	output logic      [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Per-bit chain; stage1 feeds only stage2
	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				stage1[b]  <= 1'b0;
				stage2[b]  <= 1'b0;
				stage3[b]  <= 1'b0;
				o_level[b] <= 1'b0;
			end else begin
				stage1[b] <= i_pin[b];
				stage2[b] <= stage1[b];
				stage3[b] <= stage2[b];
				if (stage2[b] == stage3[b]) begin
					o_level[b] <= stage3[b];
				end
			end
		end
	end

endmodule // pin_sync3

// file: clock_output_sync_config.sv
// Configuration logic for clock output formats, oscillator buffers, sync and test pin
module clock_output_sync_config
	import clock_output_sync_config_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_arst_n,
	// Three-wire serial programming pins
	input  wire logic                  i_ser_clk,
	input  wire logic                  i_ser_data,
	input  wire logic                  i_ser_latch,
	// Sync and reference pins
	input  wire logic                  i_sync_pin,
	input  wire logic                  i_reference_input,
	// PLL side signals, same clock
	input  wire logic                  i_fb_div_out,
	input  wire logic                  i_ref_div_out,
	input  wire logic                  i_fb_div_written,
	input  wire logic                  i_pdf_tick,
	input  wire logic                  i_phase_in_window,
	input  wire logic [LOCK_CNT_W-1:0] i_lock_qualify_count,
	// Clock output control
	output logic [NUM_OUT*FMT_W-1:0]   o_output_format_select,
	output logic [NUM_OUT-1:0]         o_clock_output_n_on,
	output logic [NUM_OUT-1:0]         o_clock_output_n_hold_low,
	// Oscillator buffers
	output logic [FMT_W-1:0]           o_osc_buffer0_format,
	output logic                       o_osc_buffer0_on,
	output logic [OSC1_AMP_W-1:0]      o_osc_buffer1_amplitude,
	output logic                       o_osc_buffer1_on,
	output logic                       o_osc_buffer0_clk,
	output logic                       o_osc_buffer1_clk,
	// Sync pin, crystal and lock
	output logic                       o_sync_pull_up,
	output logic                       o_sync_pull_down,
	output logic                       o_crystal_amp_enable,
	output logic                       o_digital_lock_detect,
	// Test and lock pin
	output logic                       o_test_lock_pin_out,
	output logic                       o_test_lock_pin_oe_n,
	// Reserved code flags
	output logic [ERR_W-1:0]           o_reserved_code
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	logic [4:0] pin_level;

	pin_sync3 #(.WIDTH(5)) u_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_pin     ({i_ser_clk, i_ser_data, i_ser_latch, i_sync_pin, i_reference_input}),
		.o_level   (pin_level)
	);

	wire ser_clk_lvl   = pin_level[4];
	wire ser_data_lvl  = pin_level[3];
	wire ser_latch_lvl = pin_level[2];
	wire sync_pin_lvl  = pin_level[1];
	wire ref_lvl       = pin_level[0];

	// ------------------------------------------------------------
	// Edge detection
	// ------------------------------------------------------------
	logic ser_clk_prev;
	logic ser_latch_prev;
	logic ref_prev;
	logic fb_prev;
	logic refdiv_prev;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ser_clk_prev   <= 1'b0;
			ser_latch_prev <= 1'b0;
			ref_prev       <= 1'b0;
			fb_prev        <= 1'b0;
			refdiv_prev    <= 1'b0;
		end else begin
			ser_clk_prev   <= ser_clk_lvl;
			ser_latch_prev <= ser_latch_lvl;
			ref_prev       <= ref_lvl;
			fb_prev        <= i_fb_div_out;
			refdiv_prev    <= i_ref_div_out;
		end
	end

	wire ser_clk_rise   = ser_clk_lvl & ~ser_clk_prev;
	wire ser_latch_rise = ser_latch_lvl & ~ser_latch_prev;
	wire ref_rise       = ref_lvl & ~ref_prev;
	wire fb_rise        = i_fb_div_out & ~fb_prev;
	wire refdiv_rise    = i_ref_div_out & ~refdiv_prev;

	// ------------------------------------------------------------
	// Serial shifter and register file
	// ------------------------------------------------------------
	logic [WORD_W-1:0] shift_word;
	logic [WORD_W-1:0] fmt_word [0:2];
	logic [WORD_W-1:0] osc_ctrl;
	logic [WORD_W-1:0] sync_ctrl;
	logic [WORD_W-1:0] test_ctrl;

	// MSB-first shift on each serial clock rising edge
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			shift_word <= REG_RESET;
		end else if (ser_clk_rise) begin
			shift_word <= {shift_word[WORD_W-2:0], ser_data_lvl};
		end
	end

	// Address sits in the low bits of the shifted word
	wire [ADDR_W-1:0] wr_addr  = shift_word[ADDR_W-1:0];
	wire              wr_fmt_a = ser_latch_rise && (wr_addr == ADDR_FMT_A);
	wire              wr_fmt_b = ser_latch_rise && (wr_addr == ADDR_FMT_B);
	wire              wr_fmt_c = ser_latch_rise && (wr_addr == ADDR_FMT_C);
	wire              wr_osc   = ser_latch_rise && (wr_addr == ADDR_OSC);
	wire              wr_sync  = ser_latch_rise && (wr_addr == ADDR_SYNC_XTAL);
	wire              wr_test  = ser_latch_rise && (wr_addr == ADDR_TEST_LOCK);

	// Format words, four nibbles each
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fmt_word[0] <= REG_RESET;
			fmt_word[1] <= REG_RESET;
			fmt_word[2] <= REG_RESET;
		end else begin
			if (wr_fmt_a) fmt_word[0] <= shift_word;
			if (wr_fmt_b) fmt_word[1] <= shift_word;
			if (wr_fmt_c) fmt_word[2] <= shift_word;
		end
	end

	// Control words; the fixed content word is accepted and has no effect
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			osc_ctrl  <= REG_RESET;
			sync_ctrl <= REG_RESET;
			test_ctrl <= REG_RESET;
		end else begin
			if (wr_osc)  osc_ctrl  <= shift_word;
			if (wr_sync) sync_ctrl <= shift_word;
			if (wr_test) test_ctrl <= shift_word;
		end
	end

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	wire [FMT_W-1:0]       osc0_fmt     = osc_ctrl[OSC0_FMT_LSB +: FMT_W];
	wire [OSC1_AMP_W-1:0]  osc1_amp     = osc_ctrl[OSC1_AMP_LSB +: OSC1_AMP_W];
	wire                   osc0_en      = osc_ctrl[OSC0_EN_BIT];
	wire                   osc1_en      = osc_ctrl[OSC1_EN_BIT];
	wire                   osc0_src     = osc_ctrl[OSC0_MUX_BIT];
	wire                   osc1_src     = osc_ctrl[OSC1_MUX_BIT];
	wire [OSC_DIV_W-1:0]   div_code     = osc_ctrl[OSC_DIV_LSB +: OSC_DIV_W];
	wire [NUM_GROUP-1:0]   group_excl   = sync_ctrl[NOSYNC_LSB +: NUM_GROUP];
	wire                   sync_pol_low = sync_ctrl[SYNC_POL_BIT];
	wire [SYNC_TYPE_W-1:0] sync_type    = sync_ctrl[SYNC_TYPE_LSB +: SYNC_TYPE_W];
	wire [TEST_SRC_W-1:0]  test_src     = test_ctrl[TEST_SRC_LSB +: TEST_SRC_W];
	wire [TEST_TYPE_W-1:0] test_type    = test_ctrl[TEST_TYPE_LSB +: TEST_TYPE_W];
	wire                   hold_lock    = test_ctrl[HOLD_LOCK_BIT];

	// ------------------------------------------------------------
	// Digital lock qualifier
	// ------------------------------------------------------------
	logic [LOCK_CNT_W-1:0] lock_cnt;
	logic                  lock_ok;

	// Zero count is reserved and treated as one
	wire [LOCK_CNT_W-1:0] lock_target = (i_lock_qualify_count == '0) ?
		LOCK_CNT_W'(1) : i_lock_qualify_count;
	wire                  lock_reached = (lock_cnt + LOCK_CNT_W'(1)) >= lock_target;

	// Any out-of-window phase sample restarts qualification
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lock_cnt <= '0;
			lock_ok  <= 1'b0;
		end else if (i_pdf_tick) begin
			if (!i_phase_in_window) begin
				lock_cnt <= '0;
				lock_ok  <= 1'b0;
			end else if (lock_reached) begin
				lock_ok  <= 1'b1;
			end else begin
				lock_cnt <= lock_cnt + LOCK_CNT_W'(1);
			end
		end
	end

	// ------------------------------------------------------------
	// Sync request sources and sequencer
	// ------------------------------------------------------------
	logic [AUTO_CNT_W-1:0] auto_cnt;
	sync_state_t           sync_state;
	logic [NUM_GROUP-1:0]  group_joined;

	// Feedback divider write stretches an automatic sync
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			auto_cnt <= '0;
		end else if (i_fb_div_written) begin
			auto_cnt <= AUTO_CNT_W'(AUTO_SYNC_CYCLES);
		end else if (auto_cnt != '0) begin
			auto_cnt <= auto_cnt - AUTO_CNT_W'(1);
		end
	end

	wire pin_sync_req  = sync_pin_lvl ^ sync_pol_low;
	wire lock_sync_req = hold_lock & ~lock_ok;
	wire auto_sync_req = (auto_cnt != '0);
	wire sync_req      = pin_sync_req | lock_sync_req | auto_sync_req;

	// Participation latched at sync start so later exclusion edits do no harm
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_state   <= SYNC_IDLE;
			group_joined <= '0;
		end else begin
			case (sync_state)
				SYNC_IDLE: begin
					if (sync_req) begin
						sync_state   <= SYNC_ACTIVE;
						group_joined <= ~group_excl;
					end
				end
				SYNC_ACTIVE: begin
					if (!sync_req) begin
						sync_state <= SYNC_IDLE;
					end
				end
				default: begin
					sync_state <= SYNC_IDLE;
				end
			endcase
		end
	end

	wire sync_active = (sync_state == SYNC_ACTIVE);

	// ------------------------------------------------------------
	// Clock output format decode, one entry per output
	// ------------------------------------------------------------
	logic [NUM_OUT*FMT_W-1:0] next_fmt_all;
	logic [NUM_OUT-1:0]       next_out_on;
	logic [NUM_OUT-1:0]       next_hold_low;
	logic [NUM_OUT-1:0]       fmt_bad;

	for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
		localparam int WI = i / FMT_PER_WORD;
		localparam int NI = i % FMT_PER_WORD;
		wire [FMT_W-1:0] fmt = fmt_word[WI][FMT_LSB + NI*FMT_W +: FMT_W];
		assign next_fmt_all[i*FMT_W +: FMT_W] = fmt;
		assign fmt_bad[i]       = (fmt > FMT_LAST_VALID);
		assign next_out_on[i]   = (fmt != FMT_POWERDOWN) && !fmt_bad[i];
		assign next_hold_low[i] = sync_active && group_joined[i/2];
	end

	// ------------------------------------------------------------
	// Oscillator divider and buffer selection
	// ------------------------------------------------------------
	logic [3:0] ref_cnt;

	wire [3:0] div_ratio = (div_code == DIV_CODE_EIGHT)   ? DIV_RATIO_EIGHT :
	                       (div_code == DIV_CODE_TWO_ALT) ? DIV_RATIO_TWO :
	                       {1'b0, div_code};
	wire       ref_wrap  = (ref_cnt + 4'h1) >= div_ratio;

	// Count reference edges modulo the divide ratio
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ref_cnt <= 4'h0;
		end else if (ref_rise) begin
			ref_cnt <= ref_wrap ? 4'h0 : ref_cnt + 4'h1;
		end
	end

	wire div_clk       = ref_cnt < (div_ratio >> 1);
	wire osc0_fmt_bad  = (osc0_fmt > FMT_LAST_VALID);
	wire next_osc0_on  = osc0_en && (osc0_fmt != FMT_POWERDOWN) && !osc0_fmt_bad;
	wire next_osc1_on  = osc1_en;
	wire next_osc0_clk = next_osc0_on & (osc0_src ? div_clk : ref_lvl);
	wire next_osc1_clk = next_osc1_on & (osc1_src ? div_clk : ref_lvl);

	// ------------------------------------------------------------
	// Sync pin type and test pin
	// ------------------------------------------------------------
	logic fb_half;
	logic ref_half;

	// Half-rate versions of the PLL divider outputs
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fb_half  <= 1'b0;
			ref_half <= 1'b0;
		end else begin
			if (fb_rise)     fb_half  <= ~fb_half;
			if (refdiv_rise) ref_half <= ~ref_half;
		end
	end

	wire sync_type_bad = (sync_type != SYNC_TYPE_PLAIN) &&
	                     (sync_type != SYNC_TYPE_PULLUP) &&
	                     (sync_type != SYNC_TYPE_PULLDN);
	wire next_pull_up  = (sync_type == SYNC_TYPE_PULLUP);
	wire next_pull_dn  = (sync_type == SYNC_TYPE_PULLDN);

	wire src_bad = !((test_src == SRC_LOW) || (test_src == SRC_LOCK) ||
	                 (test_src == SRC_FB) || (test_src == SRC_FB_HALF) ||
	                 (test_src == SRC_REF) || (test_src == SRC_REF_HALF));
	wire test_sel  = (test_src == SRC_LOCK)     ? lock_ok :
	                 (test_src == SRC_FB)       ? i_fb_div_out :
	                 (test_src == SRC_FB_HALF)  ? fb_half :
	                 (test_src == SRC_REF)      ? i_ref_div_out :
	                 (test_src == SRC_REF_HALF) ? ref_half : 1'b0;
	wire type_bad  = (test_type < TYPE_PUSH) || (test_type > TYPE_OPEN_DRAIN);
	wire test_val  = (test_type == TYPE_PUSH_INV) ? ~test_sel : test_sel;

	// Open source drives only the high level, open drain only the low level
	wire test_drive = !type_bad && !src_bad &&
	                  ((test_type == TYPE_PUSH) || (test_type == TYPE_PUSH_INV) ||
	                   ((test_type == TYPE_OPEN_SOURCE) && test_val) ||
	                   ((test_type == TYPE_OPEN_DRAIN) && !test_val));

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	wire [ERR_W-1:0] next_err = {type_bad, src_bad, sync_type_bad, osc0_fmt_bad, fmt_bad};

	// Clock output and oscillator buffer controls
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_output_format_select    <= '0;
			o_clock_output_n_on       <= '0;
			o_clock_output_n_hold_low <= '0;
			o_osc_buffer0_format      <= FMT_POWERDOWN;
			o_osc_buffer0_on          <= 1'b0;
			o_osc_buffer1_amplitude   <= '0;
			o_osc_buffer1_on          <= 1'b0;
			o_osc_buffer0_clk         <= 1'b0;
			o_osc_buffer1_clk         <= 1'b0;
		end else begin
			o_output_format_select    <= next_fmt_all;
			o_clock_output_n_on       <= next_out_on;
			o_clock_output_n_hold_low <= next_hold_low;
			o_osc_buffer0_format      <= osc0_fmt;
			o_osc_buffer0_on          <= next_osc0_on;
			o_osc_buffer1_amplitude   <= osc1_amp;
			o_osc_buffer1_on          <= next_osc1_on;
			o_osc_buffer0_clk         <= next_osc0_clk;
			o_osc_buffer1_clk         <= next_osc1_clk;
		end
	end

	// Pin type, crystal, lock and flag outputs
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sync_pull_up        <= 1'b0;
			o_sync_pull_down      <= 1'b0;
			o_crystal_amp_enable  <= 1'b0;
			o_digital_lock_detect <= 1'b0;
			o_test_lock_pin_out   <= 1'b0;
			o_test_lock_pin_oe_n  <= 1'b1;
			o_reserved_code       <= '0;
		end else begin
			o_sync_pull_up        <= next_pull_up;
			o_sync_pull_down      <= next_pull_dn;
			o_crystal_amp_enable  <= sync_ctrl[XTAL_BIT];
			o_digital_lock_detect <= lock_ok;
			o_test_lock_pin_out   <= test_val;
			o_test_lock_pin_oe_n  <= ~test_drive;
			o_reserved_code       <= next_err;
		end
	end

endmodule // clock_output_sync_config

// file: clock_output_sync_config_chk.sv
// Concurrent checks on the ports of the clock output and sync configuration block
module clock_output_sync_config_chk
	import clock_output_sync_config_pkg::*;
(
	// Clock, reset and pulse inputs
	input wire logic                       i_sys_clk, i_arst_n, i_fb_div_written, i_pdf_tick,
	// Observed outputs
	input wire logic [NUM_OUT*FMT_W-1:0]   o_output_format_select,
	input wire logic [NUM_OUT-1:0]         o_clock_output_n_on, o_clock_output_n_hold_low,
	input wire logic [FMT_W-1:0]           o_osc_buffer0_format,
	input wire logic                       o_osc_buffer0_on, o_osc_buffer0_clk,
	input wire logic                       o_digital_lock_detect, o_test_lock_pin_oe_n,
	input wire logic [ERR_W-1:0]           o_reserved_code
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	// Format code of output zero
	wire logic [3:0] nib0 = o_output_format_select[3:0];
	a_out_on_code: assert property (o_clock_output_n_on[0] == (nib0 != 4'h0 && nib0 != 4'hF))
		else $error("output zero enable disagrees with its format");
	a_fmt_flag: assert property (o_reserved_code[0] == (nib0 == 4'hF))
		else $error("output zero reserved flag wrong");
	a_osc0_gate: assert property (o_osc_buffer0_on |-> o_osc_buffer0_format != 4'h0)
		else $error("buffer zero on while powered down");
	a_osc0_quiet: assert property (!o_osc_buffer0_on && $past(!o_osc_buffer0_on) |-> !o_osc_buffer0_clk)
		else $error("buffer zero clock toggles while off");
	a_auto_sync: assert property (i_fb_div_written |-> ##[1:4] o_clock_output_n_hold_low != 12'h000)
		else $error("no hold after feedback write");
	a_pair_hold: assert property ((o_clock_output_n_hold_low & 12'h555) == ((o_clock_output_n_hold_low >> 1) & 12'h555))
		else $error("pair members held apart");
	a_lock_tick: assert property ($rose(o_digital_lock_detect) |-> $past(i_pdf_tick, 2))
		else $error("lock rose without a detector tick");
	a_rsv_release: assert property ((o_reserved_code[14] || o_reserved_code[15]) |-> o_test_lock_pin_oe_n)
		else $error("test pin driven with reserved code");
	c_auto: cover property (i_fb_div_written ##3 o_clock_output_n_hold_low != 12'h000);
	c_lock: cover property ($rose(o_digital_lock_detect));
	c_rsv: cover property (o_reserved_code[14]);
endmodule // clock_output_sync_config_chk
bind clock_output_sync_config clock_output_sync_config_chk u_clock_output_sync_config_chk (.*);

// file: host_model.sv
// Behavioural host that programs words over the three-wire serial pins
module host_model (
	// Clock
	input  wire logic i_sys_clk,
	// Serial pins
	output logic      o_ser_clk,
	output logic      o_ser_data,
	output logic      o_ser_latch
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {o_ser_clk, o_ser_data, o_ser_latch} = 3'h0;
	// Four edges per level so the pin filter stages agree
	task automatic hold();
		repeat (4) @(posedge i_sys_clk);
	endtask
	// Word goes MSB first, address last, then a latch pulse
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			o_ser_data <= w[i];
			o_ser_clk <= 1'b0;
			hold();
			o_ser_clk <= 1'b1;
			hold();
		end
		o_ser_clk <= 1'b0;
		hold();
		o_ser_latch <= 1'b1;
		hold();
		o_ser_latch <= 1'b0;
		hold();
	endtask
endmodule // host_model

// file: testbench.sv
// Self-checking bench for the clock output and sync configuration block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import clock_output_sync_config_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, sync = 1'b0, fbw = 1'b0, tick = 1'b0, win = 1'b0;
	logic sck, sdat, slat, o0on, o1on, pu, pd, xtal, dld, tout, toe_n;
	logic [47:0] fmt;
	logic [11:0] on, hold;
	logic [3:0] o0fmt;
	logic [1:0] o1amp;
	logic [15:0] rsv;
	int n_mismatch = 0, n_compared = 0;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
	clock_output_sync_config u_clock_output_sync_config (.i_sys_clk(clk), .i_arst_n(rst_n),
		.i_ser_clk(sck), .i_ser_data(sdat), .i_ser_latch(slat), .i_sync_pin(sync),
		.i_reference_input(1'b0), .i_fb_div_out(1'b0), .i_ref_div_out(1'b0),
		.i_fb_div_written(fbw), .i_pdf_tick(tick), .i_phase_in_window(win),
		.i_lock_qualify_count(14'h0003), .o_output_format_select(fmt),
		.o_clock_output_n_on(on), .o_clock_output_n_hold_low(hold), .o_osc_buffer0_format(o0fmt),
		.o_osc_buffer0_on(o0on), .o_osc_buffer1_amplitude(o1amp), .o_osc_buffer1_on(o1on),
		.o_osc_buffer0_clk(), .o_osc_buffer1_clk(), .o_sync_pull_up(pu), .o_sync_pull_down(pd),
		.o_crystal_amp_enable(xtal), .o_digital_lock_detect(dld), .o_test_lock_pin_out(tout),
		.o_test_lock_pin_oe_n(toe_n), .o_reserved_code(rsv));
	host_model u_host_model (.i_sys_clk(clk), .o_ser_clk(sck), .o_ser_data(sdat), .o_ser_latch(slat));
	initial forever #2.5 clk = ~clk;
	// Verdict and end of run
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// One register write, then let the outputs settle
	task automatic wr(input logic [31:0] w);
		u_host_model.send(w);
		repeat (8) @(posedge clk);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		wr(32'hFE10_0006);
		wr(32'h5000_0008);
		wr(32'h0000_0009);
		`CHK("fmt low", 16'hFE10, fmt[15:0])
		`CHK("fmt top", 4'h5, fmt[47:44])
		`CHK("on", 12'h806, on)
		`CHK("rsv", 4'h8, rsv[3:0])
		$display("test formats done");
		wr(32'h32C0_000A);
		`CHK("osc", 8'hF2, {o0on, o1on, o1amp, o0fmt})
		wr(32'h3200_000A);
		`CHK("osc off", 8'h32, {o0on, o1on, o1amp, o0fmt})
		$display("test osc done");
		wr(32'h0010_102B);
		`CHK("pins", 3'h5, {pu, pd, xtal})
		fbw <= 1'b1;
		@(posedge clk);
		fbw <= 1'b0;
		repeat (4) @(posedge clk);
		#1 `CHK("auto hold", 12'hFFC, hold)
		repeat (12) @(posedge clk);
		#1 `CHK("auto end", 12'h000, hold)
		sync <= 1'b1;
		repeat (8) @(posedge clk);
		#1 `CHK("pin hold", 12'hFFC, hold)
		sync <= 1'b0;
		repeat (8) @(posedge clk);
		#1 `CHK("pin end", 12'h000, hold)
		$display("test sync done");
		wr(32'h0400_000C);
		`CHK("test inv", 2'h2, {tout, toe_n})
		wr(32'h1C00_000C);
		`CHK("test rsv", 2'h3, {toe_n, rsv[14]})
		wr(32'h0380_000C);
		`CHK("lock hold", 12'hFFC, hold)
		`CHK("push low", 2'h0, {tout, toe_n})
		win <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			#1 `CHK("no lock", 1'b0, dld)
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			repeat (2) @(posedge clk);
		end
		#1 `CHK("lock", 1'b1, dld)
		`CHK("lock release", 12'h000, hold)
		$display("test pin and lock done");
		test_done();
	end
	// Watchdog far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		test_done();
	end
endmodule // testbench
